/* File: qsf_host_model.sv */
`timescale 1ns/1ps
module qsf_host_model (
	input  wire [3:0] io_i,
	output reg        sck_o,
	output reg        cs_n_o,
	output reg  [3:0] d_o,
	output reg  [3:0] d_oe_o
);
	initial
	begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		d_o = 4'h0;
		d_oe_o = 4'h0;
	end
	task sel;
	begin
		cs_n_o = 1'b0;
		d_oe_o = 4'h1;
		#320;
	end
	endtask
	task desel;
	begin
		cs_n_o = 1'b1;
		d_oe_o = 4'h0;
		#640;
	end
	endtask
	// mode 0, msb first; line 1 sampled at the rising edge
	task xb(input [7:0] tx, output [7:0] rx);
		integer i;
	begin
		for (i = 7; i >= 0; i = i - 1)
		begin
			d_o[0] = tx[i];
			#160 sck_o = 1'b1;
			rx[i] = io_i[1];
			#160 sck_o = 1'b0;
		end
	end
	endtask
endmodule // qsf_host_model

/* File: qsf_host_port.v */
`timescale 1ns/1ps
`include "qsf_port_regs.vh"
module qsf_host_port #(
	parameter QUAD_VARIANT = 1'b0
) (
	input  wire        clk_i,
	input  wire        rst_n_i,
	input  wire        sck_i,
	input  wire        cs_n_i,
	input  wire [3:0]  quad_io_lines_i,
	input  wire        pause_n_i,
	input  wire        wp_n_i,
	input  wire        protect_pin_enable_i,
	input  wire        io_config_bit_i,
	input  wire        cfg_load_i,
	input  wire        busy_i,
	input  wire [7:0]  mem_rdata_i,
	input  wire        rd_lock_i,
	output wire [3:0]  quad_io_lines_o,
	output wire [3:0]  quad_io_lines_oe_o,
	output wire [23:0] mem_addr_o,
	output wire        mem_rd_o,
	output wire        mem_sec_o,
	output wire        mem_wr_o,
	output wire [7:0]  mem_wdata_o,
	output wire        wr_bpr_o,
	output wire        prog_start_o,
	output wire        bpr_blocked_o,
	output wire        suspend_o,
	output wire        resume_o,
	output wire        soft_reset_o,
	output wire        quad_mode_o
);

localparam ST_IDLE = 3'h0;
localparam ST_CMD  = 3'h1;
localparam ST_ADDR = 3'h2;
localparam ST_WDAT = 3'h3;
localparam ST_RDAT = 3'h4;
localparam ST_DONE = 3'h5;
localparam ST_CFG  = 3'h6;

function [23:0] shift_in;
	input [23:0] a;
	input [3:0]  io;
	input [2:0]  w;
	begin
		case (w)
			3'h4: shift_in = {a[19:0], io};
			3'h2: shift_in = {a[21:0], io[1:0]};
			default: shift_in = {a[22:0], io[0]};
		endcase
	end
endfunction

function [23:0] step;
	input [23:0] a;
	input [23:0] m;
	begin
		step = (a & ~m) | ((a + 24'h000001) & m);
	end
endfunction

function [23:0] wrap_mask;
	input [1:0] s;
	begin
		case (s)
			2'h0: wrap_mask = 24'h000007;
			2'h1: wrap_mask = 24'h00000f;
			2'h2: wrap_mask = 24'h00001f;
			default: wrap_mask = 24'h00003f;
		endcase
	end
endfunction

reg [2:0]  sck_s_ff;
reg [2:0]  cs_s_ff;
reg [1:0]  pz_s_ff;
reg [1:0]  wp_s_ff;
reg [3:0]  io_s1_ff;
reg [3:0]  io_s2_ff;
reg [2:0]  st_ff;
reg [7:0]  cmd_ff;
reg [23:0] sh_ff;
reg [4:0]  cnt_ff;
reg [23:0] addr_ff;
reg [23:0] mask_ff;
reg [1:0]  wrap_ff;
reg        quad_ff;
reg        ioc_ff;
reg        wel_ff;
reg        rsten_ff;
reg [7:0]  pend_ff;
reg [7:0]  obyte_ff;
reg [2:0]  ocnt_ff;
reg        rdw_ff;
reg        wrote_ff;
reg [2:0]  dw_ff;
reg        drv_ff;
reg [3:0]  io_ff;
reg [3:0]  oe_ff;
reg [23:0] maddr_ff;
reg        mrd_ff;
reg        msec_ff;
reg        mwr_ff;
reg [7:0]  wdat_ff;
reg        wbpr_ff;
reg        pstart_ff;
reg        blk_ff;
reg        susp_ff;
reg        res_ff;
reg        srst_ff;

reg [2:0]  nxt_st;
reg [7:0]  nxt_cmd;
reg [23:0] nxt_sh;
reg [4:0]  nxt_cnt;
reg [23:0] nxt_addr;
reg [23:0] nxt_mask;
reg [1:0]  nxt_wrap;
reg        nxt_quad;
reg        nxt_ioc;
reg        nxt_wel;
reg        nxt_rsten;
reg [7:0]  nxt_pend;
reg [7:0]  nxt_obyte;
reg [2:0]  nxt_ocnt;
reg        nxt_rdw;
reg        nxt_wrote;
reg [2:0]  nxt_dw;
reg        nxt_drv;
reg [3:0]  nxt_io;
reg [23:0] nxt_maddr;
reg        nxt_mrd;
reg        nxt_msec;
reg        nxt_mwr;
reg [7:0]  nxt_wdat;
reg        nxt_wbpr;
reg        nxt_pstart;
reg        nxt_blk;
reg        nxt_susp;
reg        nxt_res;
reg        nxt_srst;
reg [2:0]  w_in;
reg [23:0] sh_in;
reg [7:0]  obyte;
reg [7:0]  stat;

// first stages feed only the second stages
wire sel      = ~cs_s_ff[1];
wire cs_fall  = ~cs_s_ff[1] & cs_s_ff[2];
wire pins_on  = ~quad_ff & ~ioc_ff; // RQ8 RQ23
wire paused   = pins_on & ~pz_s_ff[1]; // RQ9
wire rise     = sck_s_ff[1] & ~sck_s_ff[2] & ~paused; // RQ1 RQ21
wire fall     = ~sck_s_ff[1] & sck_s_ff[2] & ~paused; // RQ2 RQ21
wire wp_block = pins_on & protect_pin_enable_i & ~wp_s_ff[1]; // RQ7
wire [2:0] cw = quad_ff ? 3'h4 : 3'h1; // RQ5 RQ6

always @*
begin
	nxt_st = st_ff;
	nxt_cmd = cmd_ff;
	nxt_sh = sh_ff;
	nxt_cnt = cnt_ff;
	nxt_addr = addr_ff;
	nxt_mask = mask_ff;
	nxt_wrap = wrap_ff;
	nxt_quad = quad_ff;
	nxt_ioc = cfg_load_i ? io_config_bit_i : ioc_ff;
	nxt_wel = wel_ff;
	nxt_rsten = rsten_ff;
	nxt_pend = pend_ff;
	nxt_obyte = obyte_ff;
	nxt_ocnt = ocnt_ff;
	nxt_rdw = 1'b0;
	nxt_wrote = wrote_ff;
	nxt_dw = dw_ff;
	nxt_drv = drv_ff;
	nxt_io = io_ff;
	nxt_maddr = maddr_ff;
	nxt_mrd = 1'b0;
	nxt_msec = msec_ff;
	nxt_mwr = 1'b0;
	nxt_wdat = wdat_ff;
	nxt_wbpr = wbpr_ff;
	nxt_pstart = 1'b0;
	nxt_blk = 1'b0;
	nxt_susp = 1'b0;
	nxt_res = 1'b0;
	nxt_srst = 1'b0;
	stat = 8'h00;
	stat[`ST_BUSY_BIT] = busy_i; // RQ16
	stat[`ST_WEL_BIT] = wel_ff;
	w_in = (st_ff == ST_WDAT || st_ff == ST_CFG) ? dw_ff : cw;
	sh_in = shift_in(sh_ff, io_s2_ff, w_in);
	obyte = (ocnt_ff == 3'h0) ? pend_ff : obyte_ff;
	if (rdw_ff)
	begin
		nxt_pend = rd_lock_i ? 8'h00 : mem_rdata_i; // RQ19
	end
	if (!sel)
	begin
		nxt_st = ST_IDLE; // RQ24
		nxt_drv = 1'b0; // RQ25
		if (st_ff == ST_WDAT && wrote_ff)
		begin
			nxt_pstart = (cmd_ff != `OP_BPR_WR); // RQ4
			nxt_wel = 1'b0;
		end
	end
	else
	begin
		case (st_ff)
			ST_IDLE:
			begin
				if (cs_fall) // RQ3
				begin
					nxt_st = ST_CMD;
					nxt_cnt = 5'h00;
					nxt_wrote = 1'b0;
				end
			end
			ST_CMD:
			begin
				if (rise)
				begin
					nxt_sh = sh_in;
					nxt_cnt = cnt_ff + {2'h0, w_in};
					if (cnt_ff + {2'h0, w_in} == `CMD_BITS)
					begin
						nxt_cnt = 5'h00;
						nxt_cmd = sh_in[7:0];
						nxt_rsten = 1'b0;
						nxt_st = ST_DONE;
						nxt_dw = cw;
						nxt_mask = `LIN_MASK;
						nxt_msec = 1'b0;
						case (sh_in[7:0])
							`OP_QUAD_ON: nxt_quad = 1'b1; // RQ5 RQ22
							`OP_QUAD_OFF: nxt_quad = 1'b0;
							`OP_RST_EN: nxt_rsten = 1'b1;
							`OP_RST:
							begin
								if (rsten_ff) // RQ18
								begin
									nxt_quad = 1'b0;
									nxt_wel = 1'b0;
									nxt_wrap = `WRAP_RST;
									nxt_srst = 1'b1;
								end
							end
							`OP_WR_EN: nxt_wel = 1'b1;
							`OP_WR_DIS: nxt_wel = 1'b0;
							`OP_SUSPEND: nxt_susp = 1'b1; // RQ17
							`OP_RESUME: nxt_res = 1'b1; // RQ17
							`OP_STATUS:
							begin
								nxt_pend = stat; // RQ16
								nxt_ocnt = 3'h0;
								nxt_st = ST_RDAT;
							end
							`OP_READ: nxt_st = ST_ADDR;
							`OP_SEC_RD: nxt_st = ST_ADDR; // RQ20
							`OP_WRAP_RD:
							begin
								nxt_mask = wrap_mask(wrap_ff); // RQ14
								nxt_st = ST_ADDR;
							end
							`OP_READ2:
							begin
								if (!quad_ff) // RQ13
								begin
									nxt_dw = 3'h2;
									nxt_st = ST_ADDR;
								end
							end
							`OP_READ4:
							begin
								if (!quad_ff && ioc_ff) // RQ13
								begin
									nxt_dw = 3'h4;
									nxt_st = ST_ADDR;
								end
							end
							`OP_PROG:
							begin
								nxt_mask = `PAGE_MASK; // RQ15
								nxt_st = wel_ff ? ST_ADDR : ST_DONE;
							end
							`OP_PROG4:
							begin
								nxt_mask = `PAGE_MASK; // RQ15
								nxt_dw = 3'h4;
								nxt_st = (wel_ff && ioc_ff && !quad_ff) ? ST_ADDR : ST_DONE;
							end
							`OP_BPR_WR:
							begin
								nxt_blk = wp_block; // RQ7
								nxt_st = (wel_ff && !wp_block) ? ST_WDAT : ST_DONE;
							end
							`OP_BURST: nxt_st = ST_CFG;
							default: nxt_st = ST_DONE;
						endcase
					end
				end
			end
			ST_ADDR:
			begin
				if (rise)
				begin
					nxt_sh = sh_in;
					nxt_cnt = cnt_ff + {2'h0, w_in};
					if (cnt_ff + {2'h0, w_in} == `ADDR_BITS)
					begin
						nxt_cnt = 5'h00;
						if (cmd_ff == `OP_PROG || cmd_ff == `OP_PROG4)
						begin
							nxt_addr = sh_in;
							nxt_st = ST_WDAT;
						end
						else
						begin
							nxt_maddr = sh_in;
							nxt_mrd = 1'b1;
							nxt_rdw = 1'b1;
							nxt_msec = (cmd_ff == `OP_SEC_RD); // RQ20
							nxt_addr = step(sh_in, mask_ff); // RQ14
							nxt_ocnt = 3'h0;
							nxt_st = ST_RDAT;
						end
					end
				end
			end
			ST_WDAT:
			begin
				if (rise)
				begin
					nxt_sh = sh_in;
					nxt_cnt = cnt_ff + {2'h0, w_in};
					if (cnt_ff + {2'h0, w_in} == `CMD_BITS)
					begin
						nxt_cnt = 5'h00;
						nxt_mwr = 1'b1;
						nxt_wdat = sh_in[7:0];
						nxt_maddr = addr_ff;
						nxt_wbpr = (cmd_ff == `OP_BPR_WR);
						nxt_addr = step(addr_ff, `PAGE_MASK); // RQ15
						nxt_wrote = 1'b1;
					end
				end
			end
			ST_CFG:
			begin
				if (rise)
				begin
					nxt_sh = sh_in;
					nxt_cnt = cnt_ff + {2'h0, w_in};
					if (cnt_ff + {2'h0, w_in} == `CMD_BITS)
					begin
						nxt_wrap = sh_in[1:0]; // RQ14
						nxt_st = ST_DONE;
					end
				end
			end
			ST_RDAT:
			begin
				if (fall) // RQ2
				begin
					nxt_drv = 1'b1;
					nxt_obyte = obyte << dw_ff;
					nxt_ocnt = ocnt_ff + dw_ff;
					case (dw_ff)
						3'h4: nxt_io = obyte[7:4];
						3'h2: nxt_io = {2'h0, obyte[7:6]};
						default: nxt_io = {2'h0, obyte[7], 1'b0}; // RQ6
					endcase
					if (ocnt_ff == 3'h0)
					begin
						// next byte is fetched a whole byte time ahead
						if (cmd_ff == `OP_STATUS)
						begin
							nxt_pend = stat; // RQ16
						end
						else
						begin
							nxt_maddr = addr_ff;
							nxt_mrd = 1'b1;
							nxt_rdw = 1'b1;
							nxt_addr = step(addr_ff, mask_ff); // RQ14
						end
					end
				end
			end
			ST_DONE: nxt_st = ST_DONE;
			default: nxt_st = ST_IDLE;
		endcase
	end
end

always @(posedge clk_i)
begin
	if (!rst_n_i)
	begin
		sck_s_ff <= 3'h0;
		cs_s_ff <= 3'h7;
		pz_s_ff <= 2'h3;
		wp_s_ff <= 2'h3;
		io_s1_ff <= 4'h0;
		io_s2_ff <= 4'h0;
		st_ff <= ST_IDLE;
		cmd_ff <= 8'h00;
		sh_ff <= 24'h000000;
		cnt_ff <= 5'h00;
		addr_ff <= 24'h000000;
		mask_ff <= `LIN_MASK;
		wrap_ff <= `WRAP_RST;
		quad_ff <= 1'b0; // RQ22
		ioc_ff <= QUAD_VARIANT; // RQ11 RQ12
		wel_ff <= 1'b0;
		rsten_ff <= 1'b0;
		pend_ff <= 8'h00;
		obyte_ff <= 8'h00;
		ocnt_ff <= 3'h0;
		rdw_ff <= 1'b0;
		wrote_ff <= 1'b0;
		dw_ff <= 3'h1;
		drv_ff <= 1'b0;
		io_ff <= 4'h0;
		oe_ff <= 4'h0;
		maddr_ff <= 24'h000000;
		mrd_ff <= 1'b0;
		msec_ff <= 1'b0;
		mwr_ff <= 1'b0;
		wdat_ff <= 8'h00;
		wbpr_ff <= 1'b0;
		pstart_ff <= 1'b0;
		blk_ff <= 1'b0;
		susp_ff <= 1'b0;
		res_ff <= 1'b0;
		srst_ff <= 1'b0;
	end
	else
	begin
		sck_s_ff <= {sck_s_ff[1:0], sck_i};
		cs_s_ff <= {cs_s_ff[1:0], cs_n_i};
		pz_s_ff <= {pz_s_ff[0], pause_n_i};
		wp_s_ff <= {wp_s_ff[0], wp_n_i};
		io_s1_ff <= quad_io_lines_i;
		io_s2_ff <= io_s1_ff;
		st_ff <= nxt_st;
		cmd_ff <= nxt_cmd;
		sh_ff <= nxt_sh;
		cnt_ff <= nxt_cnt;
		addr_ff <= nxt_addr;
		mask_ff <= nxt_mask;
		wrap_ff <= nxt_wrap;
		quad_ff <= nxt_quad;
		ioc_ff <= nxt_ioc;
		wel_ff <= nxt_wel;
		rsten_ff <= nxt_rsten;
		pend_ff <= nxt_pend;
		obyte_ff <= nxt_obyte;
		ocnt_ff <= nxt_ocnt;
		rdw_ff <= nxt_rdw;
		wrote_ff <= nxt_wrote;
		dw_ff <= nxt_dw;
		drv_ff <= nxt_drv;
		io_ff <= nxt_io;
		// pause floats the lines but keeps the phase for resume
		oe_ff <= (nxt_drv && !paused) ? ((nxt_dw == 3'h4) ? 4'hf :
			(nxt_dw == 3'h2) ? 4'h3 : 4'h2) : 4'h0; // RQ25 RQ9
		maddr_ff <= nxt_maddr;
		mrd_ff <= nxt_mrd;
		msec_ff <= nxt_msec;
		mwr_ff <= nxt_mwr;
		wdat_ff <= nxt_wdat;
		wbpr_ff <= nxt_wbpr;
		pstart_ff <= nxt_pstart;
		blk_ff <= nxt_blk;
		susp_ff <= nxt_susp;
		res_ff <= nxt_res;
		srst_ff <= nxt_srst;
	end
end

assign quad_io_lines_o    = io_ff;
assign quad_io_lines_oe_o = oe_ff;
assign mem_addr_o         = maddr_ff;
assign mem_rd_o           = mrd_ff;
assign mem_sec_o          = msec_ff;
assign mem_wr_o           = mwr_ff;
assign mem_wdata_o        = wdat_ff;
assign wr_bpr_o           = wbpr_ff;
assign prog_start_o       = pstart_ff;
assign bpr_blocked_o      = blk_ff;
assign suspend_o          = susp_ff;
assign resume_o           = res_ff;
assign soft_reset_o       = srst_ff;
assign quad_mode_o        = quad_ff;

endmodule // qsf_host_port

/* File: qsf_port_checker_assertions.sv */
`timescale 1ns/1ps
module qsf_port_checker (
	input wire       clk_i,
	input wire       rst_n_i,
	input wire       sck_i,
	input wire       cs_n_i,
	input wire       pause_n_i,
	input wire       wp_n_i,
	input wire       protect_pin_enable_i,
	input wire       mem_rd_o,
	input wire [3:0] quad_io_lines_o,
	input wire [3:0] quad_io_lines_oe_o,
	input wire       bpr_blocked_o,
	input wire       suspend_o,
	input wire       resume_o,
	input wire       soft_reset_o,
	input wire       quad_mode_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// select passes a synchroniser, so a few cycles of slack
	oe_idle_a: assert property (cs_n_i [*6] |-> quad_io_lines_oe_o == 4'h0)
		else $error("lines driven while deselected");
	sel_drive_a: assert property (quad_io_lines_oe_o != 4'h0 |-> !$past(cs_n_i, 5))
		else $error("lines driven without select");
	oe_legal_a: assert property (quad_io_lines_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
		else $error("illegal output enable pattern");
	io_fall_a: assert property (($changed(quad_io_lines_o) && quad_io_lines_oe_o != 4'h0
		&& !cs_n_i) |-> (!$past(sck_i, 2) || !$past(sck_i, 3) || !$past(sck_i, 4)))
		else $error("output changed away from a falling edge");
	rd_pulse_a: assert property (mem_rd_o |=> !mem_rd_o)
		else $error("read request longer than one cycle");
	block_cause_a: assert property (bpr_blocked_o |-> protect_pin_enable_i
		&& !$past(wp_n_i, 3) && !quad_mode_o)
		else $error("protect block without its cause");
	pulse_excl_a: assert property ((suspend_o || resume_o) |=> !suspend_o && !resume_o)
		else $error("suspend or resume not a single pulse");
	sreset_quad_a: assert property (soft_reset_o |-> ##[1:2] !quad_mode_o)
		else $error("soft reset left quad mode on");
	pause_float_a: assert property ((!pause_n_i && !cs_n_i && !quad_mode_o) [*5]
		|-> quad_io_lines_oe_o == 4'h0)
		else $error("lines driven while paused");
endmodule // qsf_port_checker

/* File: qsf_port_regs.vh */
`ifndef QSF_PORT_REGS_VH
`define QSF_PORT_REGS_VH
// Function
// RQ1 - command, address and write bits are taken on serial clock rising edges
// RQ2 - output bits change on serial clock falling edges
// RQ3 - a new command starts only on a select high-to-low transition
// RQ4 - host keeps select low for a whole command and its write data
// RQ5 - after enter-quad all four data lines carry command, address and data
// RQ6 - after reset input and output use separate lines
// RQ7 - protect pin, pin enable and io config decide protect register blocking
// RQ8 - protect pin counts only outside quad operation
// RQ9 - pause pin low while selected freezes the link until released
// RQ10 - system holds pause high when unused; it acts only in single-wire mode
// RQ11 - first variant starts with protect and pause pins active
// RQ12 - second variant starts with upper two lines active for quad data
// RQ13 - single-wire protocol supports one, two and four line transfers
// RQ14 - burst reads wrap in 8, 16, 32 or 64 byte windows, or run linear
// RQ15 - page program takes up to 256 bytes, one or four lines
// RQ16 - status shows a busy flag which the host polls
// RQ17 - program or erase can be suspended and resumed
// RQ18 - a software reset command returns the port to its reset state
// RQ19 - read-locked parameter blocks return zero data
// RQ20 - a security area with unique identifier is readable by its own command
// RQ21 - host idles serial clock low or high; both are accepted
// RQ22 - port starts in single-wire mode and enters quad only on command
// RQ23 - io config one disables the protect pin and its enable bit
// RQ24 - select high abandons any partial command and returns to idle
// RQ25 - data lines float while deselected or outside a data output phase
`define OP_READ 8'h03
`define OP_READ2 8'h3b
`define OP_READ4 8'h6b
`define OP_WRAP_RD 8'h0c
`define OP_PROG 8'h02
`define OP_PROG4 8'h32
`define OP_STATUS 8'h05
`define OP_WR_EN 8'h06
`define OP_WR_DIS 8'h04
`define OP_QUAD_ON 8'h38
`define OP_QUAD_OFF 8'hff
`define OP_RST_EN 8'h66
`define OP_RST 8'h99
`define OP_SUSPEND 8'hb0
`define OP_RESUME 8'h30
`define OP_BPR_WR 8'h42
`define OP_SEC_RD 8'h88
`define OP_BURST 8'hc0
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define CMD_BITS 5'h08
`define ADDR_BITS 5'h18
`define PAGE_MASK 24'h0000ff
`define LIN_MASK 24'hffffff
`define WRAP_RST 2'h0
`endif

/* File: quad_serial_flash_host_port_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares = compares + 1; if ((s) !== (e)) begin \
	err_total = err_total + 1; $display("mismatch %s exp %h got %h", n, e, s); end end
module quad_serial_flash_host_port_tb_top;
	reg         clk_i = 1'b0;
	reg         rst_n_i = 1'b0;
	reg         pause_n_i = 1'b1;
	reg         wp_n_i = 1'b1;
	reg         protect_pin_enable_i = 1'b0;
	reg         io_config_bit_i = 1'b0;
	reg         cfg_load_i = 1'b0;
	reg         busy_i = 1'b0;
	reg         rd_lock_i = 1'b0;
	reg         flip = 1'b0;
	reg  [7:0]  mem_rdata_i = 8'h00;
	reg  [3:0]  n_blk = 4'h0;
	reg  [3:0]  n_sus = 4'h0;
	reg  [3:0]  n_res = 4'h0;
	reg  [3:0]  n_srst = 4'h0;
	reg  [3:0]  n_wr = 4'h0;
	reg  [3:0]  n_ps = 4'h0;
	reg  [7:0]  last_wd = 8'h00;
	reg  [23:0] last_wa = 24'h000000;
	reg         last_bpr = 1'b0;
	integer     err_total = 0;
	integer     compares = 0;
	wire        sck_i;
	wire        cs_n_i;
	wire [3:0]  h_d;
	wire [3:0]  h_oe;
	wire [3:0]  io_q;
	wire [3:0]  oe_q;
	wire [3:0]  quad_io_lines_i;
	wire [23:0] mem_addr_o;
	wire        mem_sec_o;
	wire        mem_wr_o;
	wire [7:0]  mem_wdata_o;
	wire        wr_bpr_o;
	wire        prog_start_o;
	wire        bpr_blocked_o;
	wire        suspend_o;
	wire        resume_o;
	wire        soft_reset_o;
	wire        quad_mode_o;
	always #20 clk_i = ~clk_i;
	// undriven lines toggle so a stale level is never read as valid
	assign quad_io_lines_i = (oe_q & io_q) | (~oe_q & h_oe & h_d) | (~oe_q & ~h_oe & {4{flip}});
	always @(negedge clk_i)
	begin
		flip <= ~flip;
		mem_rdata_i <= mem_addr_o[7:0] ^ 8'ha5;
	end
	always @(posedge clk_i)
	begin
		n_blk <= n_blk + {3'h0, bpr_blocked_o};
		n_sus <= n_sus + {3'h0, suspend_o};
		n_res <= n_res + {3'h0, resume_o};
		n_srst <= n_srst + {3'h0, soft_reset_o};
		n_wr <= n_wr + {3'h0, mem_wr_o};
		n_ps <= n_ps + {3'h0, prog_start_o};
		if (mem_wr_o)
		begin
			last_wd <= mem_wdata_o;
			last_wa <= mem_addr_o;
			last_bpr <= wr_bpr_o;
		end
	end
	qsf_host_model h (.io_i(quad_io_lines_i), .sck_o(sck_i), .cs_n_o(cs_n_i), .d_o(h_d),
		.d_oe_o(h_oe));
	qsf_host_port #(.QUAD_VARIANT(1'b0)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sck_i(sck_i),
		.cs_n_i(cs_n_i), .quad_io_lines_i(quad_io_lines_i), .pause_n_i(pause_n_i),
		.wp_n_i(wp_n_i), .protect_pin_enable_i(protect_pin_enable_i),
		.io_config_bit_i(io_config_bit_i), .cfg_load_i(cfg_load_i), .busy_i(busy_i),
		.mem_rdata_i(mem_rdata_i), .rd_lock_i(rd_lock_i), .quad_io_lines_o(io_q),
		.quad_io_lines_oe_o(oe_q), .mem_addr_o(mem_addr_o), .mem_rd_o(), .mem_sec_o(mem_sec_o),
		.mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .wr_bpr_o(wr_bpr_o),
		.prog_start_o(prog_start_o),
		.bpr_blocked_o(bpr_blocked_o), .suspend_o(suspend_o), .resume_o(resume_o),
		.soft_reset_o(soft_reset_o), .quad_mode_o(quad_mode_o));
	task complete_run;
	begin
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask
	task cmd(input [7:0] op);
		reg [7:0] r;
	begin
		h.sel;
		h.xb(op, r);
		h.desel;
	end
	endtask
	task ld_cfg(input v);
	begin
		@(negedge clk_i) io_config_bit_i = v;
		cfg_load_i = 1'b1;
		@(negedge clk_i) cfg_load_i = 1'b0;
	end
	endtask
	task test_read(input [7:0] op, input [23:0] a, input lk, input [15:0] exp);
		reg [7:0] r0;
		reg [7:0] r1;
	begin
		rd_lock_i = lk;
		h.sel;
		h.xb(op, r0);
		h.xb(a[23:16], r0);
		h.xb(a[15:8], r0);
		h.xb(a[7:0], r0);
		h.xb(8'h00, r0);
		h.xb(8'h00, r1);
		h.desel;
		`CHK("read data", exp, {r0, r1})
		`CHK("oe after deselect", 4'h0, oe_q)
		`CHK("security select", op == 8'h88, mem_sec_o)
		rd_lock_i = 1'b0;
		$display("test read done");
	end
	endtask
	task test_prog;
		reg [7:0] r;
	begin
		cmd(8'h06);
		h.sel;
		h.xb(8'h02, r);
		h.xb(8'h00, r);
		h.xb(8'h01, r);
		h.xb(8'hff, r);
		h.xb(8'h5a, r);
		h.xb(8'hc3, r);
		h.desel;
		`CHK("write count", 4'h2, n_wr)
		`CHK("write address", 24'h000100, last_wa)
		`CHK("write data", 8'hc3, last_wd)
		`CHK("protect write flag", 1'b0, last_bpr)
		`CHK("program start", 4'h1, n_ps)
		$display("test program done");
	end
	endtask
	task test_wrap;
		reg [7:0] r;
	begin
		h.sel;
		h.xb(8'hc0, r);
		h.xb(8'h01, r);
		h.desel;
		test_read(8'h0c, 24'h00002f, 1'b0, 16'h8a85);
		$display("test wrap done");
	end
	endtask
	task test_status(input bsy);
		reg [7:0] r;
	begin
		busy_i = bsy;
		h.sel;
		h.xb(8'h03, r);
		h.xb(8'h05, r);
		h.desel;
		h.sel;
		h.xb(8'h05, r);
		h.xb(8'h00, r);
		h.desel;
		`CHK("status", {1'b0, bsy}, r[1:0])
		$display("test status done");
	end
	endtask
	task test_protect;
	begin
		wp_n_i = 1'b0;
		cmd(8'h06);
		cmd(8'h42);
		`CHK("blocked, enable off", 4'h0, n_blk)
		protect_pin_enable_i = 1'b1;
		cmd(8'h06);
		cmd(8'h42);
		`CHK("blocked, pin low", 4'h1, n_blk)
		ld_cfg(1'b1);
		cmd(8'h06);
		cmd(8'h42);
		`CHK("blocked, io config", 4'h1, n_blk)
		ld_cfg(1'b0);
		wp_n_i = 1'b1;
		$display("test protect done");
	end
	endtask
	task test_pause;
		reg [7:0] r;
	begin
		h.sel;
		h.xb(8'h03, r);
		h.xb(8'h00, r);
		pause_n_i = 1'b0;
		#320;
		h.xb(8'hff, r);
		pause_n_i = 1'b1;
		#320;
		h.xb(8'h00, r);
		h.xb(8'h20, r);
		h.xb(8'h00, r);
		h.desel;
		`CHK("paused read", 8'h85, r)
		$display("test pause done");
	end
	endtask
	task test_ctl;
	begin
		`CHK("quad at start", 1'b0, quad_mode_o)
		cmd(8'hb0);
		cmd(8'h30);
		cmd(8'h99);
		`CHK("suspends", 4'h1, n_sus)
		`CHK("resumes", 4'h1, n_res)
		`CHK("lone reset", 4'h0, n_srst)
		cmd(8'h66);
		cmd(8'h99);
		`CHK("soft reset", 4'h1, n_srst)
		cmd(8'h38);
		`CHK("quad on", 1'b1, quad_mode_o)
		$display("test control done");
	end
	endtask
	initial
	begin
		repeat (4) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clk_i);
		test_read(8'h03, 24'h123456, 1'b0, 16'hf3f2);
		test_read(8'h03, 24'h000010, 1'b1, 16'h0000);
		test_read(8'h88, 24'h000040, 1'b0, 16'he5e4);
		test_status(1'b1);
		test_status(1'b0);
		test_pause;
		test_protect;
		test_prog;
		test_status(1'b0);
		test_wrap;
		test_ctl;
		complete_run;
	end
	initial
	begin
		#1000000;
		err_total = err_total + 1;
		complete_run;
	end
endmodule // quad_serial_flash_host_port_tb_top
bind qsf_host_port qsf_port_checker chk (.*);
